// *** logic/wuc_pkg.sv ***
package wuc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] WAKEUP_CONTROL_IDX = 10'h017;
  localparam logic [9:0] SYMBOL_COUNT_IDX = 10'h01a;
  localparam logic [9:0] IRQ_STATUS_IDX = 10'h040;
  localparam logic [9:0] IRQ_CLEAR_IDX = 10'h041;
  localparam logic [9:0] IRQ_ENABLE_IDX = 10'h042;
  localparam logic [9:0] EFFECTIVE_IDX = 10'h043;
  localparam int ADDR_W = 12;

  // wakeup_control fields
  localparam int CRIT_LSB = 0;
  localparam int CRIT_W = 3;
  localparam int UFB_BIT = 3;
  localparam int LVL_SEL_BIT = 4;
  localparam int PAT_UNIT_BIT = 5;
  localparam int PAR_WU_BIT = 6;
  localparam logic [7:0] WAKEUP_CONTROL_RST = 8'h04;
  localparam logic [7:0] WAKEUP_CONTROL_MASK = 8'h7f;
  localparam logic [6:0] SYMBOL_COUNT_RST = 7'h00;
  localparam logic [6:0] PATTERN_MIN_COUNT = 7'h11;

  // interrupt status bits
  localparam int EVT_W = 3;
  localparam int EVT_RESERVED = 0;
  localparam int EVT_SHORT_PATTERN = 1;
  localparam int EVT_OVERRIDE = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

  localparam logic [2:0] CRIT_PATTERN = 3'h0;
  localparam logic [2:0] CRIT_RANDOM = 3'h1;
  localparam logic [2:0] CRIT_EQUAL = 3'h2;
  localparam logic [2:0] CRIT_SYMBOL_SYNC = 3'h3;
  localparam logic [2:0] CRIT_STRENGTH = 3'h4;
  localparam logic [2:0] CRIT_RECOGNITION = 3'h5;

  localparam logic [1:0] EXT_PROC_SYNC = 2'h1;
  localparam logic [1:0] EXT_PROC_LEVEL = 2'h2;

  // receiver search operating modes
  localparam logic [1:0] MODE_OTHER = 2'h0;
  localparam logic [1:0] MODE_FAST_FALLBACK = 2'h1;
  localparam logic [1:0] MODE_PERMANENT = 2'h2;
  localparam logic [1:0] MODE_CONST_ON_OFF = 2'h3;

  localparam logic LVL_STRENGTH = 1'b0;
  localparam logic LVL_RECOGNITION = 1'b1;

endpackage : wuc_pkg

// *** logic/wuc_resolve_if.sv ***
`timescale 1ns/100ps
interface wuc_resolve_if;
  logic [2:0] criterion_raw;
  logic ultrafast_fallback_enable;
  logic parallel_level_select;
  logic [1:0] external_processing_setting;
  logic [1:0] search_mode;
  logic [2:0] criterion_eff;
  logic level_parallel;
  logic level_criterion;
  logic count_used;
  logic reserved_code;
  logic overridden;

  modport ctrl (
    output criterion_raw, ultrafast_fallback_enable, parallel_level_select,
    output external_processing_setting, search_mode,
    input criterion_eff, level_parallel, level_criterion, count_used, reserved_code, overridden
  );
  modport res (
    input criterion_raw, ultrafast_fallback_enable, parallel_level_select,
    input external_processing_setting, search_mode,
    output criterion_eff, level_parallel, level_criterion, count_used, reserved_code, overridden
  );
endinterface : wuc_resolve_if

// *** logic/wuc_resolve.sv ***
`timescale 1ns/100ps
module wuc_resolve (
  wuc_resolve_if.res rif
);

  function automatic logic wuc_is_data(input logic [2:0] c);
    wuc_is_data = (c == wuc_pkg::CRIT_PATTERN) || (c == wuc_pkg::CRIT_RANDOM) ||
                  (c == wuc_pkg::CRIT_EQUAL) || (c == wuc_pkg::CRIT_SYMBOL_SYNC);
  endfunction : wuc_is_data

  always_comb begin
    rif.criterion_eff = rif.criterion_raw;
    rif.overridden = 1'b0;
    if (rif.external_processing_setting == wuc_pkg::EXT_PROC_LEVEL) begin
      rif.criterion_eff = wuc_pkg::CRIT_STRENGTH;
    end else if ((rif.external_processing_setting == wuc_pkg::EXT_PROC_SYNC) &&
                 wuc_is_data(rif.criterion_raw)) begin
      rif.criterion_eff = wuc_pkg::CRIT_SYMBOL_SYNC;
    end
    if (rif.criterion_eff != rif.criterion_raw) begin
      rif.overridden = 1'b1;
    end
    rif.reserved_code = (rif.criterion_raw > wuc_pkg::CRIT_RECOGNITION);
    rif.count_used = (rif.criterion_eff != wuc_pkg::CRIT_SYMBOL_SYNC);
    rif.level_parallel = rif.ultrafast_fallback_enable && wuc_is_data(rif.criterion_eff) &&
                         (rif.search_mode != wuc_pkg::MODE_OTHER);
    if (rif.external_processing_setting == wuc_pkg::EXT_PROC_LEVEL) begin
      rif.level_criterion = wuc_pkg::LVL_STRENGTH;
    end else begin
      rif.level_criterion = rif.parallel_level_select;
    end
  end

endmodule : wuc_resolve

// *** logic/wuc_top.sv ***
`timescale 1ns/100ps
// Functional notes
// - The 3-bit criterion field picks pattern, random, equal, symbol sync, strength or recognition.
// - External processing 01 turns a pattern, random or equal criterion into symbol sync.
// - Under symbol sync the wake-up symbol count is not used.
// - External processing 10 forces the signal strength criterion whatever was written.
// - Ultrafast fall back with a data criterion adds a parallel level check in the three search modes.
// - Bit 4 picks the parallel level check, strength or recognition, and drives the level criterion output with ultrafast fall back on or off.
// - External processing 10 forces strength as the parallel level check.
// - Bit 5 matches the wake-up pattern in chips when clear and in bits when set.
module wuc_top (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] external_processing_setting_in,
  input wire logic [1:0] search_mode_in,
  output logic [2:0] wakeup_criterion_out,
  output logic level_parallel_out,
  output logic level_criterion_out,
  output logic pattern_unit_select_out,
  output logic parallel_wakeup_enable_out,
  output logic [6:0] wakeup_symbol_count_out,
  output logic count_used_out,
  output logic irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] wakeup_control;
    logic [6:0] symbol_count;
    logic [wuc_pkg::EVT_W-1:0] irq_status;
    logic [wuc_pkg::EVT_W-1:0] irq_enable;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] criterion;
    logic level_parallel;
    logic level_criterion;
    logic count_used;
    logic overridden;
    logic irq;
  } wuc_state_t;

  wuc_state_t state_q;
  wuc_state_t state_d;

  //////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  function automatic logic wuc_hit(input logic [11:0] addr, input logic [9:0] idx);
    wuc_hit = (addr == {idx, 2'b00});
  endfunction : wuc_hit

  function automatic logic wuc_mapped(input logic [11:0] addr);
    if (wuc_hit(addr, wuc_pkg::WAKEUP_CONTROL_IDX)) begin
      wuc_mapped = 1'b1;
    end else if (wuc_hit(addr, wuc_pkg::SYMBOL_COUNT_IDX)) begin
      wuc_mapped = 1'b1;
    end else if (wuc_hit(addr, wuc_pkg::IRQ_STATUS_IDX)) begin
      wuc_mapped = 1'b1;
    end else if (wuc_hit(addr, wuc_pkg::IRQ_CLEAR_IDX)) begin
      wuc_mapped = 1'b1;
    end else if (wuc_hit(addr, wuc_pkg::IRQ_ENABLE_IDX)) begin
      wuc_mapped = 1'b1;
    end else if (wuc_hit(addr, wuc_pkg::EFFECTIVE_IDX)) begin
      wuc_mapped = 1'b1;
    end else begin
      wuc_mapped = 1'b0;
    end
  endfunction : wuc_mapped

  // byte lane 0 merge; registers are eight bits or less
  function automatic logic [7:0] wuc_merge(input logic [7:0] old, input logic [31:0] wdata,
                                           input logic [3:0] strb);
    if (strb[0]) begin
      wuc_merge = wdata[7:0];
    end else begin
      wuc_merge = old;
    end
  endfunction : wuc_merge

  //////////////////////////////////////////////////////////////////////////////
  // criterion resolution

  wuc_resolve_if rif ();

  wuc_resolve u_resolve (
    .rif(rif)
  );

  logic [7:0] ctrl_next;
  logic setup_phase;
  logic access_phase;
  logic wr_ctrl;
  logic wr_count;
  logic wr_clear;
  logic wr_enable;
  logic [wuc_pkg::EVT_W-1:0] events;
  logic [wuc_pkg::EVT_W-1:0] clear_bits;
  logic [6:0] count_next;
  logic [7:0] count_merged;

  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign wr_ctrl = access_phase && pwrite_in && wuc_hit(paddr_in, wuc_pkg::WAKEUP_CONTROL_IDX);
  assign wr_count = access_phase && pwrite_in && wuc_hit(paddr_in, wuc_pkg::SYMBOL_COUNT_IDX);
  assign wr_clear = access_phase && pwrite_in && wuc_hit(paddr_in, wuc_pkg::IRQ_CLEAR_IDX);
  assign wr_enable = access_phase && pwrite_in && wuc_hit(paddr_in, wuc_pkg::IRQ_ENABLE_IDX);

  always_comb begin
    if (wr_ctrl) begin
      ctrl_next = wuc_merge(state_q.wakeup_control, pwdata_in, pstrb_in) & wuc_pkg::WAKEUP_CONTROL_MASK;
    end else begin
      ctrl_next = state_q.wakeup_control;
    end
    count_merged = wuc_merge({1'b0, state_q.symbol_count}, pwdata_in, pstrb_in);
    if (wr_count) begin
      count_next = count_merged[6:0];
    end else begin
      count_next = state_q.symbol_count;
    end
  end

  // resolve from the value about to be stored so outputs follow a write by one edge
  assign rif.criterion_raw = ctrl_next[wuc_pkg::CRIT_LSB +: wuc_pkg::CRIT_W];
  assign rif.ultrafast_fallback_enable = ctrl_next[wuc_pkg::UFB_BIT];
  assign rif.parallel_level_select = ctrl_next[wuc_pkg::LVL_SEL_BIT];
  assign rif.external_processing_setting = external_processing_setting_in;
  assign rif.search_mode = search_mode_in;

  //////////////////////////////////////////////////////////////////////////////
  // events

  always_comb begin
    events = '0;
    // unused criterion code written
    events[wuc_pkg::EVT_RESERVED] = wr_ctrl && rif.reserved_code;
    // pattern detection armed with a count too short to fill the comparator
    events[wuc_pkg::EVT_SHORT_PATTERN] = (wr_ctrl || wr_count) &&
                                         (rif.criterion_eff == wuc_pkg::CRIT_PATTERN) &&
                                         (count_next < wuc_pkg::PATTERN_MIN_COUNT);
    // external processing starts forcing a different criterion
    events[wuc_pkg::EVT_OVERRIDE] = rif.overridden && !state_q.overridden;
    if (wr_clear) begin
      clear_bits = pwdata_in[wuc_pkg::EVT_W-1:0];
    end else begin
      clear_bits = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux

  function automatic logic [31:0] wuc_read(input wuc_state_t s, input logic [11:0] addr);
    wuc_read = 32'h0000_0000;
    if (wuc_hit(addr, wuc_pkg::WAKEUP_CONTROL_IDX)) begin
      wuc_read[7:0] = s.wakeup_control;
    end else if (wuc_hit(addr, wuc_pkg::SYMBOL_COUNT_IDX)) begin
      wuc_read[6:0] = s.symbol_count;
    end else if (wuc_hit(addr, wuc_pkg::IRQ_STATUS_IDX)) begin
      wuc_read[wuc_pkg::EVT_W-1:0] = s.irq_status;
    end else if (wuc_hit(addr, wuc_pkg::IRQ_ENABLE_IDX)) begin
      wuc_read[wuc_pkg::EVT_W-1:0] = s.irq_enable;
    end else if (wuc_hit(addr, wuc_pkg::EFFECTIVE_IDX)) begin
      wuc_read[2:0] = s.criterion;
      wuc_read[3] = s.level_parallel;
      wuc_read[4] = s.level_criterion;
      wuc_read[5] = s.count_used;
      wuc_read[6] = s.overridden;
    end else begin
      wuc_read = 32'h0000_0000;
    end
  endfunction : wuc_read

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    state_d.wakeup_control = ctrl_next;
    state_d.symbol_count = count_next;
    if (wr_enable) begin
      state_d.irq_enable = pwdata_in[wuc_pkg::EVT_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    state_d.irq_status = (state_q.irq_status & ~clear_bits) | events;
    state_d.irq = |(state_d.irq_status & state_d.irq_enable);
    state_d.criterion = rif.criterion_eff;
    state_d.level_parallel = rif.level_parallel;
    state_d.level_criterion = rif.level_criterion;
    state_d.count_used = rif.count_used;
    state_d.overridden = rif.overridden;
    // read data and error are captured in the setup cycle, ready in the access cycle
    if (setup_phase) begin
      state_d.pslverr = !wuc_mapped(paddr_in) ||
                        (pwrite_in && (wuc_hit(paddr_in, wuc_pkg::IRQ_STATUS_IDX) ||
                                       wuc_hit(paddr_in, wuc_pkg::EFFECTIVE_IDX)));
      if (pwrite_in) begin
        state_d.prdata = 32'h0000_0000;
      end else begin
        state_d.prdata = wuc_read(state_q, paddr_in);
      end
    end
    if (!reset_n_in) begin
      state_d.wakeup_control = wuc_pkg::WAKEUP_CONTROL_RST;
      state_d.symbol_count = wuc_pkg::SYMBOL_COUNT_RST;
      state_d.irq_status = wuc_pkg::EVT_RST;
      state_d.irq_enable = wuc_pkg::EVT_RST;
      state_d.prdata = 32'h0000_0000;
      state_d.pslverr = 1'b0;
      state_d.criterion = wuc_pkg::CRIT_STRENGTH;
      state_d.level_parallel = 1'b0;
      state_d.level_criterion = wuc_pkg::LVL_STRENGTH;
      state_d.count_used = 1'b1;
      state_d.overridden = 1'b0;
      state_d.irq = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state_q <= state_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready_out = access_phase;
  assign prdata_out = state_q.prdata;
  assign pslverr_out = access_phase && state_q.pslverr;
  assign wakeup_criterion_out = state_q.criterion;
  assign level_parallel_out = state_q.level_parallel;
  assign level_criterion_out = state_q.level_criterion;
  assign pattern_unit_select_out = state_q.wakeup_control[wuc_pkg::PAT_UNIT_BIT];
  // plain enable bit; software guarantees matching modulation across setups
  assign parallel_wakeup_enable_out = state_q.wakeup_control[wuc_pkg::PAR_WU_BIT];
  assign wakeup_symbol_count_out = state_q.symbol_count;
  assign count_used_out = state_q.count_used;
  assign irq_out = state_q.irq;

endmodule : wuc_top

// *** verification/wuc_checker.sv ***
`timescale 1ns/100ps
module wuc_checker (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [1:0] external_processing_setting_in,
  input wire logic [1:0] search_mode_in,
  input wire logic [2:0] wakeup_criterion_out,
  input wire logic level_parallel_out,
  input wire logic level_criterion_out,
  input wire logic pattern_unit_select_out,
  input wire logic count_used_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the control register as written over the bus
  logic [7:0] ctrl_q;
  logic [1:0] ext;
  assign ext = external_processing_setting_in;
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ctrl_q <= wuc_pkg::WAKEUP_CONTROL_RST;
    end else if (psel_in && penable_in && pwrite_in && pstrb_in[0]
                 && paddr_in == {wuc_pkg::WAKEUP_CONTROL_IDX, 2'b00}) begin
      ctrl_q <= pwdata_in[7:0] & wuc_pkg::WAKEUP_CONTROL_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  crit_pass_a: assert property (ext == 2'h0 |=> wakeup_criterion_out == ctrl_q[2:0])
    else $error("criterion not passed through");
  sync_map_a: assert property (ext == 2'h1 ##1 (ctrl_q[2:0] < 3'h3) |->
    wakeup_criterion_out == 3'h3) else $error("criterion not mapped to symbol sync");
  count_off_a: assert property (count_used_out == (wakeup_criterion_out != 3'h3))
    else $error("count use does not follow criterion");
  level_force_a: assert property (ext == 2'h2 |=> wakeup_criterion_out == 3'h4)
    else $error("strength criterion not forced");
  par_level_a: assert property (ext == 2'h0 && search_mode_in != 2'h0 |=>
    level_parallel_out == (ctrl_q[3] && ctrl_q[2:0] < 3'h4)) else $error("parallel level wrong");
  par_mode_a: assert property (search_mode_in == 2'h0 |=> !level_parallel_out)
    else $error("parallel level outside search modes");
  lvl_select_a: assert property (ext != 2'h2 ##1 (ctrl_q[3] && ctrl_q[2:0] < 3'h4) |->
    level_criterion_out == ctrl_q[4]) else $error("level criterion select wrong");
  lvl_strength_a: assert property (ext == 2'h2 |=> !level_criterion_out)
    else $error("strength not forced as level criterion");
  unit_sel_a: assert property (pattern_unit_select_out == ctrl_q[5])
    else $error("pattern unit select wrong");
endmodule : wuc_checker

bind wuc_top wuc_checker i_checker (
  .sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in),
  .external_processing_setting_in(external_processing_setting_in),
  .search_mode_in(search_mode_in),
  .wakeup_criterion_out(wakeup_criterion_out),
  .level_parallel_out(level_parallel_out),
  .level_criterion_out(level_criterion_out),
  .pattern_unit_select_out(pattern_unit_select_out),
  .count_used_out(count_used_out)
);

// *** verification/wuc_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  localparam logic [11:0] a_ctrl = {wuc_pkg::WAKEUP_CONTROL_IDX, 2'b00};
  localparam logic [11:0] a_cnt = {wuc_pkg::SYMBOL_COUNT_IDX, 2'b00};
  localparam logic [11:0] a_sts = {wuc_pkg::IRQ_STATUS_IDX, 2'b00};
  localparam logic [11:0] a_clr = {wuc_pkg::IRQ_CLEAR_IDX, 2'b00};
  localparam logic [11:0] a_ena = {wuc_pkg::IRQ_ENABLE_IDX, 2'b00};
  localparam logic [11:0] a_eff = {wuc_pkg::EFFECTIVE_IDX, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] ext = 2'h0;
  logic [1:0] mode = 2'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, lpar, lcrit, punit, pwu, cused, irq;
  logic [2:0] crit, expc;
  logic [6:0] cnt;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] cv [6] = '{8'h08, 8'h18, 8'h1b, 8'h18, 8'h1c, 8'h10};
  logic [1:0] md [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
  logic ep [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  initial begin
    forever #50 clk = ~clk;
  end
  wuc_top i_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .external_processing_setting_in(ext), .search_mode_in(mode),
    .wakeup_criterion_out(crit), .level_parallel_out(lpar), .level_criterion_out(lcrit),
    .pattern_unit_select_out(punit), .parallel_wakeup_enable_out(pwu), .wakeup_symbol_count_out(cnt),
    .count_used_out(cused), .irq_out(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask : apb
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin : main
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, a_ctrl, 32'h0);
    `CHK(rdat, 32'h4)
    `CHK(crit, 3'h4)
    for (int x = 0; x < 3; x++) begin
      ext <= 2'(x);
      for (int c = 0; c < 6; c++) begin
        apb(1'b1, a_ctrl, 32'(c));
        settle();
        expc = (x == 2) ? 3'h4 : (x == 1 && c < 3) ? 3'h3 : 3'(c);
        `CHK(crit, expc)
        `CHK(cused, expc != 3'h3)
      end
    end
    ext <= 2'h0;
    for (int i = 0; i < 6; i++) begin
      mode <= md[i];
      apb(1'b1, a_ctrl, {24'h0, cv[i]});
      settle();
      `CHK(lpar, ep[i])
      if (ep[i]) `CHK(lcrit, cv[i][4])
    end
    ext <= 2'h2;
    apb(1'b1, a_ctrl, 32'h18);
    settle();
    `CHK(lcrit, 1'b0)
    ext <= 2'h0;
    apb(1'b1, a_ctrl, 32'hff);
    apb(1'b0, a_ctrl, 32'h0);
    `CHK(rdat, 32'h7f)
    settle();
    `CHK({punit, pwu}, 2'b11)
    apb(1'b1, a_ctrl, 32'h00);
    settle();
    `CHK({punit, pwu}, 2'b00)
    // lane 0 disabled: the control write must be dropped
    pstrb <= 4'he;
    apb(1'b1, a_ctrl, 32'h20);
    pstrb <= 4'hf;
    apb(1'b0, a_ctrl, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b1, a_clr, 32'h7);
    apb(1'b1, a_ena, 32'h2);
    apb(1'b1, a_cnt, 32'h10);
    apb(1'b1, a_ctrl, 32'h00);
    settle();
    `CHK(irq, 1'b1)
    apb(1'b0, a_sts, 32'h0);
    `CHK(rdat, 32'h2)
    apb(1'b1, a_ena, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    apb(1'b1, a_ena, 32'h2);
    settle();
    `CHK(irq, 1'b1)
    apb(1'b1, a_clr, 32'h2);
    apb(1'b1, a_cnt, 32'h11);
    apb(1'b1, a_ctrl, 32'h06);
    settle();
    `CHK(irq, 1'b0)
    apb(1'b0, a_sts, 32'h0);
    `CHK(rdat, 32'h1)
    `CHK(cnt, 7'h11)
    apb(1'b0, a_eff, 32'h0);
    `CHK(rdat, 32'h26)
    apb(1'b0, a_ena, 32'h0);
    `CHK({rerr, rdat}, {1'b0, 32'h2})
    apb(1'b0, 12'h200, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    apb(1'b1, a_sts, 32'h7);
    `CHK(rerr, 1'b1)
    // override event: a data criterion written while external processing is 01
    apb(1'b1, a_clr, 32'h7);
    ext <= 2'h1;
    apb(1'b1, a_ctrl, 32'h00);
    apb(1'b0, a_sts, 32'h0);
    `CHK(rdat, 32'h4)
    apb(1'b0, a_eff, 32'h0);
    `CHK(rdat, 32'h43)
    // reset in mid-run returns every register to its reset value
    ext <= 2'h0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, a_cnt, 32'h0);
    `CHK({irq, cnt, rdat}, {1'b0, 7'h00, 32'h0})
    apb(1'b0, a_ctrl, 32'h0);
    `CHK({crit, rdat}, {3'h4, 32'h4})
    results();
  end : main
endmodule : tb
